// [hw/asq_pkg.sv]
// constants for the aux and limit conversion sequencer
package asq_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // per-step conversion time and totals in microseconds
  localparam int unsigned STEP_FAST_US = 58;
  localparam int unsigned STEP_NORM_US = 145;
  localparam int unsigned STEP_FILT_US = 29818;
  localparam int unsigned AUX_TOT_FAST_US = 1825;
  localparam int unsigned AUX_TOT_NORM_US = 3862;
  localparam int unsigned AUX_TOT_FILT_US = 335498;
  localparam int unsigned CV_TOT_FAST_US = 1328;
  localparam int unsigned CV_TOT_NORM_US = 2753;
  localparam int unsigned CV_TOT_FILT_US = 234899;
  localparam int unsigned SKEW_FIRST_US = 194;
  localparam int unsigned SKEW_SECOND_US = 147;
  // cycle counts
  localparam logic [25:0] STEP_FAST_CYC = 26'(STEP_FAST_US * CLK_MHZ);
  localparam logic [25:0] STEP_NORM_CYC = 26'(STEP_NORM_US * CLK_MHZ);
  localparam logic [25:0] STEP_FILT_CYC = 26'(STEP_FILT_US * CLK_MHZ);
  localparam logic [25:0] AUX_TOT_FAST_CYC = 26'(AUX_TOT_FAST_US * CLK_MHZ);
  localparam logic [25:0] AUX_TOT_NORM_CYC = 26'(AUX_TOT_NORM_US * CLK_MHZ);
  localparam logic [25:0] AUX_TOT_FILT_CYC = 26'(AUX_TOT_FILT_US * CLK_MHZ);
  localparam logic [25:0] CV_TOT_FAST_CYC = 26'(CV_TOT_FAST_US * CLK_MHZ);
  localparam logic [25:0] CV_TOT_NORM_CYC = 26'(CV_TOT_NORM_US * CLK_MHZ);
  localparam logic [25:0] CV_TOT_FILT_CYC = 26'(CV_TOT_FILT_US * CLK_MHZ);
  // register word indices (byte address = 4 * index)
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_THRESH = 6'h01;
  localparam logic [5:0] IDX_PATH = 6'h02;
  localparam logic [5:0] IDX_ISTAT = 6'h03;
  localparam logic [5:0] IDX_IMASK = 6'h04;
  localparam logic [5:0] IDX_FLAGS = 6'h05;
  localparam logic [5:0] IDX_CELL0 = 6'h10;
  localparam logic [5:0] IDX_AUX0 = 6'h20;
  // command, mode and selection codes
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_AUX = 2'h1;
  localparam logic [1:0] CMD_AUX_RED = 2'h2;
  localparam logic [1:0] CMD_CELL_AUX = 2'h3;
  localparam logic [1:0] MODE_FAST = 2'h0;
  localparam logic [1:0] MODE_NORM = 2'h1;
  localparam logic [1:0] MODE_FILT = 2'h2;
  localparam logic [3:0] SEL_ALL = 4'h0;
  localparam logic [3:0] SEL_REF2 = 4'hA;
  localparam logic [3:0] AUX_REF2_IDX = 4'h9;
  localparam logic [3:0] AUX_ALL_STEPS = 4'hA;
  localparam logic [3:0] CV_STEPS = 4'h7;
  localparam logic [3:0] CV_GPIO1_STEP = 4'h2;
  localparam logic [3:0] CV_GPIO2_STEP = 4'h5;
  localparam int unsigned NCELL = 15;
  localparam int unsigned NAUX = 10;
  localparam int unsigned NCONV = 3;
  localparam int unsigned CELLS_PER_CONV = 5;
  // interrupt status bits
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_OV = 1;
  localparam int unsigned IRQ_UV = 2;
  localparam int unsigned IRQ_FAULT = 3;
  // reset values and fault code
  localparam logic [31:0] THRESH_RST = 32'h0000_0000;
  localparam logic [1:0] PATH_RST = 2'h3;
  localparam logic [11:0] FAULT_HI = 12'hFF0;
endpackage : asq_pkg

// [hw/asq_seq.sv]
// aux and limit conversion sequencer with wishbone registers
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module asq_seq
  import asq_pkg::*;
#(
  parameter int unsigned US_DIV = 1
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  output logic             busy_o,
  output logic             conv_start_o,
  output logic      [1:0]  conv_cmd_o,
  output logic      [1:0]  conv_mode_o,
  output logic      [3:0]  conv_step_o,
  output logic      [3:0]  conv_aux_o,
  input  wire logic [15:0] conv_res1_i,
  input  wire logic [15:0] conv_res2_i,
  input  wire logic [15:0] conv_res3_i,
  input  wire logic [15:0] conv_red_i
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN} asq_state_t;

  // cycle counts divided by US_DIV; 1 keeps the real durations
  localparam logic [25:0] STEP_FAST    = 26'(STEP_FAST_CYC / US_DIV);
  localparam logic [25:0] STEP_NORM    = 26'(STEP_NORM_CYC / US_DIV);
  localparam logic [25:0] STEP_FILT    = 26'(STEP_FILT_CYC / US_DIV);
  localparam logic [25:0] AUX_TOT_FAST = 26'(AUX_TOT_FAST_CYC / US_DIV);
  localparam logic [25:0] AUX_TOT_NORM = 26'(AUX_TOT_NORM_CYC / US_DIV);
  localparam logic [25:0] AUX_TOT_FILT = 26'(AUX_TOT_FILT_CYC / US_DIV);
  localparam logic [25:0] CV_TOT_FAST  = 26'(CV_TOT_FAST_CYC / US_DIV);
  localparam logic [25:0] CV_TOT_NORM  = 26'(CV_TOT_NORM_CYC / US_DIV);
  localparam logic [25:0] CV_TOT_FILT  = 26'(CV_TOT_FILT_CYC / US_DIV);

  asq_state_t  state;
  logic [1:0]  cmd;
  logic [1:0]  mode;
  logic [3:0]  sel;
  logic [3:0]  step;
  logic [25:0] step_cnt;
  logic [25:0] tot_cnt;
  logic [31:0] thresh;
  logic [1:0]  path_sel;
  logic [3:0]  istat;
  logic [3:0]  imask;
  logic [14:0] uv_flags;
  logic [14:0] ov_flags;
  logic [14:0] stg_uv;
  logic [14:0] stg_ov;
  logic        stg_fault;
  logic [15:0] cell_res [NCELL];
  logic [15:0] aux_res  [NAUX];
  logic [15:0] stg_cell [NCELL];
  logic [15:0] stg_aux  [NAUX];
  logic [15:0] conv_res [NCONV];

  logic        wb_req;
  logic        wb_wr;
  logic [5:0]  widx;
  logic [31:0] wmask;
  logic        start;
  logic [25:0] step_len;
  logic [25:0] tot_len;
  logic [3:0]  nsteps;
  logic        step_end;
  logic        seq_end;
  logic [3:0]  aux_idx;
  logic [2:0]  cv_slot;
  logic        red_on;
  logic [15:0] aux_val;
  logic [3:0]  mism;
  logic [3:0]  next_istat;

  assign conv_res[0] = conv_res1_i;
  assign conv_res[1] = conv_res2_i;
  assign conv_res[2] = conv_res3_i;

  // bus decode
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;
  assign widx   = wb_adr_i[7:2];
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // command accepted only when idle with a legal mode and selection
  assign start = wb_wr & (widx == IDX_CTRL) & wb_sel_i[0] & (state == ST_IDLE)
               & (wb_dat_i[1:0] != CMD_NONE) & (wb_dat_i[3:2] != 2'h3)
               & (wb_dat_i[7:4] <= SEL_REF2);

  // timing per mode; both aux variants share one table
  always_comb
  begin
    case (mode)
      MODE_FAST:
      begin
        step_len = STEP_FAST;
        tot_len  = (cmd == CMD_CELL_AUX) ? CV_TOT_FAST : AUX_TOT_FAST;
      end
      MODE_NORM:
      begin
        step_len = STEP_NORM;
        tot_len  = (cmd == CMD_CELL_AUX) ? CV_TOT_NORM : AUX_TOT_NORM;
      end
      default:
      begin
        step_len = STEP_FILT;
        tot_len  = (cmd == CMD_CELL_AUX) ? CV_TOT_FILT : AUX_TOT_FILT;
      end
    endcase
  end

  // number of conversion steps in this command
  always_comb
  begin
    if (cmd == CMD_CELL_AUX)
      nsteps = CV_STEPS;
    else if (sel == SEL_ALL)
      nsteps = AUX_ALL_STEPS;
    else
      nsteps = 4'h1;
  end

  assign step_end = (state == ST_RUN) & (step_cnt == step_len - 26'h1) & (step < nsteps);
  assign seq_end  = (state == ST_RUN) & (tot_cnt == tot_len - 26'h1);

  // aux slot of the current step: gpio1..5, ref2, gpio6..9
  always_comb
  begin
    if (sel != SEL_ALL)
      aux_idx = sel - 4'h1;
    else if (step < 4'h5)
      aux_idx = step;
    else if (step == 4'h5)
      aux_idx = AUX_REF2_IDX;
    else
      aux_idx = step - 4'h1;
  end

  // combined schedule: gpio steps sit between cell steps to keep skew short
  always_comb
  begin
    case (step)
      4'h0: cv_slot = 3'h0;
      4'h1: cv_slot = 3'h1;
      4'h3: cv_slot = 3'h2;
      4'h4: cv_slot = 3'h3;
      4'h6: cv_slot = 3'h4;
      default: cv_slot = 3'h7;
    endcase
  end

  // redundant check of the first converter result
  assign red_on = (cmd == CMD_AUX_RED) & (path_sel <= 2'h1);
  generate
    for (genvar n = 0; n < 4; n++)
    begin : g_nib
      assign mism[n] = red_on & (conv_res1_i[4*n+3:4*n] != conv_red_i[4*n+3:4*n]);
    end
  endgenerate
  assign aux_val = (|mism) ? {FAULT_HI, mism} : conv_res1_i;

  // sequencer state and counters
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state    <= ST_IDLE;
      cmd      <= CMD_NONE;
      mode     <= MODE_FAST;
      sel      <= SEL_ALL;
      step     <= 4'h0;
      step_cnt <= 26'h0;
      tot_cnt  <= 26'h0;
    end
    else if (ce_i)
    begin
      case (state)
        ST_IDLE:
        begin
          if (start)
          begin
            state    <= ST_RUN;
            cmd      <= wb_dat_i[1:0];
            mode     <= wb_dat_i[3:2];
            sel      <= wb_dat_i[7:4];
            step     <= 4'h0;
            step_cnt <= 26'h0;
            tot_cnt  <= 26'h0;
          end
        end
        ST_RUN:
        begin
          tot_cnt <= tot_cnt + 26'h1;
          if (seq_end)
            state <= ST_IDLE;
          if (step_end)
          begin
            step     <= step + 4'h1;
            step_cnt <= 26'h0;
          end
          else
            step_cnt <= step_cnt + 26'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // staging of results and limit flags at each step end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stg_uv    <= 15'h0000;
      stg_ov    <= 15'h0000;
      stg_fault <= 1'b0;
      for (int i = 0; i < NCELL; i++)
        stg_cell[i] <= 16'h0000;
      for (int i = 0; i < NAUX; i++)
        stg_aux[i] <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (start)
        stg_fault <= 1'b0;
      else if (step_end && cmd != CMD_CELL_AUX)
      begin
        stg_aux[aux_idx] <= aux_val;
        if (|mism)
          stg_fault <= 1'b1;
      end
      else if (step_end && cv_slot == 3'h7)
        stg_aux[(step == CV_GPIO1_STEP) ? 0 : 1] <= conv_res1_i;
      else if (step_end)
      begin
        for (int c = 0; c < NCONV; c++)
        begin
          stg_cell[c*CELLS_PER_CONV + cv_slot] <= conv_res[c];
          stg_ov[c*CELLS_PER_CONV + cv_slot] <= conv_res[c] > thresh[31:16];
          stg_uv[c*CELLS_PER_CONV + cv_slot] <= conv_res[c] < thresh[15:0];
        end
      end
    end
  end

  // commit staged results at sequence end; limit flags only after a combined command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      uv_flags <= 15'h0000;
      ov_flags <= 15'h0000;
      for (int i = 0; i < NCELL; i++)
        cell_res[i] <= 16'h0000;
      for (int i = 0; i < NAUX; i++)
        aux_res[i] <= 16'h0000;
    end
    else if (ce_i && seq_end)
    begin
      cell_res <= stg_cell;
      aux_res  <= stg_aux;
      if (cmd == CMD_CELL_AUX)
      begin
        uv_flags <= stg_uv;
        ov_flags <= stg_ov;
      end
    end
  end

  // software registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      thresh   <= THRESH_RST;
      path_sel <= PATH_RST;
      imask    <= 4'h0;
    end
    else if (ce_i && wb_wr)
    begin
      if (widx == IDX_THRESH)
        thresh <= (thresh & ~wmask) | (wb_dat_i & wmask);
      if (widx == IDX_PATH && wb_sel_i[0])
        path_sel <= wb_dat_i[1:0];
      if (widx == IDX_IMASK && wb_sel_i[0])
        imask <= wb_dat_i[3:0];
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_comb
  begin
    next_istat = istat;
    if (wb_wr && widx == IDX_ISTAT && wb_sel_i[0])
      next_istat = next_istat & ~wb_dat_i[3:0];
    if (seq_end)
    begin
      next_istat[IRQ_DONE] = 1'b1;
      if (cmd == CMD_CELL_AUX && |stg_ov)
        next_istat[IRQ_OV] = 1'b1;
      if (cmd == CMD_CELL_AUX && |stg_uv)
        next_istat[IRQ_UV] = 1'b1;
      if (stg_fault)
        next_istat[IRQ_FAULT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      istat <= 4'h0;
    else if (ce_i)
      istat <= next_istat;
  end

  // wishbone ack and read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i)
      begin
        if (widx == IDX_CTRL)
          wb_dat_o <= {(state == ST_RUN), 23'h0, sel, mode, cmd};
        else if (widx == IDX_THRESH)
          wb_dat_o <= thresh;
        else if (widx == IDX_PATH)
          wb_dat_o <= {30'h0, path_sel};
        else if (widx == IDX_ISTAT)
          wb_dat_o <= {28'h0, istat};
        else if (widx == IDX_IMASK)
          wb_dat_o <= {28'h0, imask};
        else if (widx == IDX_FLAGS)
          wb_dat_o <= {1'b0, ov_flags, 1'b0, uv_flags};
        else if (widx >= IDX_CELL0 && widx < IDX_CELL0 + 6'(NCELL))
          wb_dat_o <= {16'h0, cell_res[4'(widx - IDX_CELL0)]};
        else if (widx >= IDX_AUX0 && widx < IDX_AUX0 + 6'(NAUX))
          wb_dat_o <= {16'h0, aux_res[4'(widx - IDX_AUX0)]};
      end
    end
  end

  // converter control outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_start_o <= 1'b0;
      conv_step_o  <= 4'h0;
      conv_aux_o   <= 4'h0;
    end
    else if (ce_i)
    begin
      conv_start_o <= (state == ST_RUN) & (step_cnt == 26'h0) & (step < nsteps);
      conv_step_o  <= step;
      conv_aux_o   <= aux_idx;
    end
  end

  assign conv_cmd_o  = cmd;
  assign conv_mode_o = mode;
  assign busy_o      = (state == ST_RUN);
  assign irq_o       = |(istat & imask);

endmodule : asq_seq
`default_nettype wire

// [tb/asq_seq_properties.sv]
// port assertions for the aux and limit sequencer
`timescale 1ns/1ps
`default_nettype none
module asq_seq_properties
  import asq_pkg::*;
#(
  parameter int unsigned US_DIV = 1
)(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        busy_o,
  input wire logic        conv_start_o,
  input wire logic [1:0]  conv_cmd_o,
  input wire logic [1:0]  conv_mode_o,
  input wire logic [3:0]  conv_step_o,
  input wire logic [3:0]  conv_aux_o
);
  // expected totals from the documented durations, same time scale
  localparam logic [25:0] AUX_TOT_FAST = 26'(AUX_TOT_FAST_CYC / US_DIV);
  localparam logic [25:0] AUX_TOT_NORM = 26'(AUX_TOT_NORM_CYC / US_DIV);
  localparam logic [25:0] AUX_TOT_FILT = 26'(AUX_TOT_FILT_CYC / US_DIV);
  localparam logic [25:0] CV_TOT_FAST  = 26'(CV_TOT_FAST_CYC / US_DIV);
  localparam logic [25:0] CV_TOT_NORM  = 26'(CV_TOT_NORM_CYC / US_DIV);
  localparam logic [25:0] CV_TOT_FILT  = 26'(CV_TOT_FILT_CYC / US_DIV);
  logic [25:0] run_cnt;
  logic [25:0] tot;
  logic        cv;
  assign cv = conv_cmd_o == CMD_CELL_AUX;
  // enabled cycles spent busy
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !busy_o)
      run_cnt <= 26'h0;
    else if (ce_i)
      run_cnt <= run_cnt + 26'h1;
  end
  // expected run length from command and mode
  always_comb
  begin
    case (conv_mode_o)
      MODE_FAST: tot = cv ? CV_TOT_FAST : AUX_TOT_FAST;
      MODE_NORM: tot = cv ? CV_TOT_NORM : AUX_TOT_NORM;
      default:   tot = cv ? CV_TOT_FILT : AUX_TOT_FILT;
    endcase
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence wb_req;
    wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o;
  endsequence
  sequence run_end;
    $fell(busy_o);
  endsequence
  sequence aux_start;
    conv_start_o && !cv;
  endsequence
  run_len_a: assert property (run_end |-> run_cnt == tot)
    else $error("run length differs");
  ack_resp_a: assert property (wb_req |=> wb_ack_o)
    else $error("no ack");
  ack_once_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack too long");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  start_pulse_a: assert property (conv_start_o && ce_i |=> !conv_start_o)
    else $error("start too long");
  start_busy_a: assert property (conv_start_o |-> busy_o)
    else $error("start while idle");
  ref2_slot_a: assert property (aux_start ##0 conv_step_o == 4'h5 |-> conv_aux_o == AUX_REF2_IDX)
    else $error("reference out of place");
  late_gpio_a: assert property (aux_start ##0 conv_step_o > 4'h5 |-> conv_aux_o == conv_step_o - 4'h1)
    else $error("late input out of place");
  early_gpio_a: assert property (aux_start ##0 (conv_step_o != 4'h0 && conv_step_o < 4'h5) |-> conv_aux_o == conv_step_o)
    else $error("early input out of place");
  cv_steps_a: assert property (conv_start_o && cv |-> conv_step_o < CV_STEPS)
    else $error("combined step out of range");
  cmd_hold_a: assert property (busy_o [*3] |-> $stable(conv_cmd_o) && $stable(conv_mode_o))
    else $error("command changed while busy");
endmodule : asq_seq_properties
bind asq_seq asq_seq_properties #(
  .US_DIV(US_DIV)
) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .busy_o(busy_o), .conv_start_o(conv_start_o),
  .conv_cmd_o(conv_cmd_o), .conv_mode_o(conv_mode_o), .conv_step_o(conv_step_o),
  .conv_aux_o(conv_aux_o)
);
`default_nettype wire

// [tb/asq_conv_model.sv]
// behavioural converter front end feeding the sequencer
`timescale 1ns/1ps
`default_nettype none
module asq_conv_model (
  input  wire logic [3:0]  step_i,
  input  wire logic [7:0]  base_i,
  input  wire logic [15:0] err_i,
  output logic      [15:0] res1_o,
  output logic      [15:0] res2_o,
  output logic      [15:0] res3_o,
  output logic      [15:0] red_o
);
  // results carry converter, base and step so misplacement shows
  assign res1_o = {4'h1, base_i, step_i};
  assign res2_o = {4'h2, base_i, step_i};
  assign res3_o = {4'h3, base_i, step_i};
  // redundant machine copies the first converter with injected errors
  assign red_o = res1_o ^ err_i;
endmodule : asq_conv_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the aux and limit sequencer
`timescale 1ns/1ps
`default_nettype none
module tb
  import asq_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  be = 4'hF;
  logic [7:0]  adr = 8'h00;
  logic [7:0]  base = 8'h00;
  logic [7:0]  b;
  logic [31:0] dat = 32'h0;
  logic [15:0] err = 16'h0;
  logic [15:0] pc = 16'h0;
  logic [14:0] uvf;
  logic [14:0] ovf;
  wire logic [31:0] dat_o;
  wire logic ack, irq, busy, start;
  wire logic [1:0] cmd_o, mode_o;
  wire logic [3:0] step_o, aux_o;
  wire logic [15:0] r1, r2, r3, rr;
  int          num_errors = 0;
  int          n_checks = 0;
  int          seed = 32'h8A51;
  logic [31:0] expq[$];

  always #5 clk = ~clk;

  // durations divided by 2000 keep the documented ratios in a short run
  asq_seq #(.US_DIV(2000)) DUT (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .irq_o(irq), .busy_o(busy), .conv_start_o(start), .conv_cmd_o(cmd_o),
    .conv_mode_o(mode_o), .conv_step_o(step_o), .conv_aux_o(aux_o), .conv_res1_i(r1),
    .conv_res2_i(r2), .conv_res3_i(r3), .conv_red_i(rr));

  asq_conv_model u_conv (.step_i(step_o), .base_i(base), .err_i(err),
    .res1_o(r1), .res2_o(r2), .res3_o(r3), .red_o(rr));

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one classic cycle, held until ack
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= be;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      num_errors++;
      print_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  task automatic go(input logic [1:0] c, input logic [1:0] m, input logic [3:0] s);
    bus(8'h00, 1'b1, {24'h0, s, m, c});
  endtask : go

  task automatic idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000)
    begin
      num_errors++;
      print_verdict();
    end
  endtask : idle

  function automatic logic [15:0] auxv(input int j);
    int s;
    s = (j < 5) ? j : (j == 9) ? 5 : j + 1;
    return {4'h1, base, 4'(s)};
  endfunction : auxv

  function automatic logic [15:0] cellv(input int i);
    int k;
    k = i % 5;
    k = (k < 2) ? k : (k == 4) ? 6 : k + 1;
    return {4'(i / 5 + 1), base, 4'(k)};
  endfunction : cellv

  // read data against the oldest note
  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0)
      chk(dat_o, expq.pop_front());
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h3);
    bus(8'hFC, 1'b1, 32'hFFFF_FFFF);
    rd(8'hFC, 32'h0);
    bus(8'h10, 1'b1, 32'h1);
    // random byte enables on the threshold word, then a command without byte 0
    be = 4'($random(seed));
    bus(8'h04, 1'b1, 32'hA5C3_96E1);
    rd(8'h04, {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & 32'hA5C3_96E1);
    be = 4'hE;
    go(CMD_AUX, MODE_FAST, SEL_ALL);
    chk(busy, 1'b0);
    be = 4'hF;
    err <= 16'h0010;
    // all ten inputs, plain and redundant with path off
    for (int m = 0; m < 3; m++)
      for (int c = 1; c < 3; c++)
      begin
        base <= 8'($random(seed));
        go(2'(c), 2'(m), SEL_ALL);
        idle();
        chk(irq, 1'b1);
        for (int j = 0; j < 10; j++)
          rd(8'(8'h80 + 4 * j), {16'h0, auxv(j)});
        rd(8'h0C, 32'h1);
        bus(8'h0C, 1'b1, 32'hF);
        chk(irq, 1'b0);
      end
    // each input alone
    for (int s = 1; s < 11; s++)
    begin
      base <= 8'($random(seed));
      go(2'h1, MODE_FAST, 4'(s));
      idle();
      rd(8'(8'h7C + 4 * s), {16'h0, 4'h1, base, 4'h0});
    end
    bus(8'h0C, 1'b1, 32'hF);
    bus(8'h10, 1'b1, 32'h8);
    // redundancy faults on both paths
    for (int p = 0; p < 2; p++)
    begin
      bus(8'h08, 1'b1, 32'(p));
      err <= p ? 16'h1100 : 16'h0010;
      go(CMD_AUX_RED, MODE_FAST, SEL_ALL);
      idle();
      chk(irq, 1'b1);
      for (int j = 0; j < 10; j++)
        rd(8'(8'h80 + 4 * j), p ? 32'hFF0C : 32'hFF02);
      rd(8'h0C, 32'h9);
      bus(8'h0C, 1'b1, 32'hF);
    end
    // combined runs with thresholds on sample boundaries
    for (int m = 0; m < 3; m++)
    begin
      b = 8'($random(seed));
      base <= b;
      bus(8'h04, 1'b1, {4'h3, b, 4'h3, 4'h1, b, 4'h3});
      go(CMD_CELL_AUX, 2'(m), SEL_ALL);
      go(CMD_AUX, MODE_FAST, SEL_ALL);
      rd(8'h00, {1'b1, 23'h0, 4'h0, 2'(m), 2'h3});
      rd(8'h40, {16'h0, pc});
      ce <= 1'b0;
      repeat (4) @(posedge clk);
      ce <= 1'b1;
      idle();
      chk(irq, 1'b0);
      for (int i = 0; i < 15; i++)
      begin
        uvf[i] = cellv(i) < {4'h1, b, 4'h3};
        ovf[i] = cellv(i) > {4'h3, b, 4'h3};
        rd(8'(8'h40 + 4 * i), {16'h0, cellv(i)});
      end
      rd(8'h80, {16'h0, 4'h1, b, CV_GPIO1_STEP});
      rd(8'h84, {16'h0, 4'h1, b, CV_GPIO2_STEP});
      rd(8'h14, {1'b0, ovf, 1'b0, uvf});
      rd(8'h0C, {29'h0, |uvf, |ovf, 1'b1});
      bus(8'h0C, 1'b1, 32'hF);
      pc = cellv(0);
    end
    // bad fields are refused
    go(CMD_AUX, MODE_FAST, 4'hB);
    chk(busy, 1'b0);
    go(CMD_AUX, 2'h3, SEL_ALL);
    chk(busy, 1'b0);
    rd(8'h00, 32'h0000_000B);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
